// >>> common/wdl_pkg.sv
// Package for the watchdog timer and power LED control block.
// Assumes a 50 MHz system clock and an 8-bit register port.
package wdl_pkg;

    // Register offsets. All five register offsets are fixed.
    localparam logic [7:0] OFS_TIMEBASE   = 8'hF1;
    localparam logic [7:0] OFS_TIMEOUT    = 8'hF2;
    localparam logic [7:0] OFS_CONFIG     = 8'hF3;
    localparam logic [7:0] OFS_CONTROL    = 8'hF4;
    localparam logic [7:0] OFS_PINCFG     = 8'hF5;

    // Reset values.
    localparam logic [7:0] RST_TIMEBASE   = 8'h00;
    localparam logic [7:0] RST_TIMEOUT    = 8'h00;
    localparam logic [7:0] RST_CONFIG     = 8'h00;
    localparam logic [7:0] RST_CONTROL    = 8'h00;
    localparam logic [7:0] RST_PINCFG     = 8'h00;

    // Field positions.
    localparam int TB_MINUTES_BIT   = 7;
    localparam int CFG_JOY_BIT      = 0;
    localparam int CFG_KBD_BIT      = 1;
    localparam int CFG_MOUSE_BIT    = 2;
    localparam int CFG_LEDWDT_BIT   = 3;
    localparam int CFG_IRQ_LSB      = 4;
    localparam int CTL_STATUS_BIT   = 0;
    localparam int CTL_LED_BIT      = 1;
    localparam int CTL_FORCE_BIT    = 2;
    localparam int CTL_KBCEN_BIT    = 3;
    localparam int CTL_RSVD_BIT     = 4;
    // Pin configuration: alternate bits 0..2, polarity bits 4..6, IR 7.
    localparam int PIN_ALT_STAT_BIT = 0;
    localparam int PIN_ALT_LED_BIT  = 1;
    localparam int PIN_ALT_B_BIT    = 2;
    localparam int PIN_POL_STAT_BIT = 4;
    localparam int PIN_POL_LED_BIT  = 5;
    localparam int PIN_POL_B_BIT    = 6;
    localparam int PIN_IR_BIT       = 7;

    // Timing counts.
    localparam int CLK_HZ           = 50000000;
    localparam int HALF_SEC_MS      = 500;
    localparam int HALF_SEC_CYC     = CLK_HZ / 1000 * HALF_SEC_MS;
    localparam int SEC_PER_MIN      = 60;

    // Counter states.
    typedef enum logic [1:0] {
        WDL_IDLE = 2'b00,
        WDL_RUN  = 2'b01,
        WDL_DONE = 2'b11
    } wdl_state_t;

endpackage

// >>> core/wdl_prescaler.sv
// Prescaler giving half-second, second and minute ticks for the block.
// Assumes a single clock domain and a synchronous clock enable.
`timescale 1ns/1ps
`default_nettype none
module wdl_prescaler
    import wdl_pkg::*;
#(
    parameter int HALF_CYC = HALF_SEC_CYC
) (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic clk_en,
    output logic      half_tick,
    output logic      sec_tick,
    output logic      min_tick
);

    logic [25:0] div_ff;
    logic        phase_ff;
    logic [5:0]  sec_cnt_ff;

    ////////////////////////////////////////////////////////////////////
    // Half-second divider; the LED toggles on each tick, giving 1 Hz.
    assign half_tick = clk_en && (div_ff == 26'(HALF_CYC - 1));
    assign sec_tick  = half_tick && phase_ff;
    assign min_tick  = sec_tick && (sec_cnt_ff == 6'(SEC_PER_MIN - 1));

    // Counters clear on reset so ticks are aligned to reset release.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            div_ff     <= 26'h0000000;
            phase_ff   <= 1'b0;
            sec_cnt_ff <= 6'h00;
        end else if (clk_en) begin
            div_ff <= half_tick ? 26'h0000000 : div_ff + 26'h0000001;
            if (half_tick) begin
                phase_ff <= ~phase_ff;
            end
            if (sec_tick) begin
                sec_cnt_ff <= min_tick ? 6'h00 : sec_cnt_ff + 6'h01;
            end
        end
    end

endmodule
`default_nettype wire

// >>> core/wdl_sync.sv
// Three-stage synchroniser with agreement filter for a pin input.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module wdl_sync (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic clk_en,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic level_ff;

    ////////////////////////////////////////////////////////////////////
    // A change counts only once stages two and three agree.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s1_ff    <= 1'b0;
            s2_ff    <= 1'b0;
            s3_ff    <= 1'b0;
            level_ff <= 1'b0;
        end else if (clk_en) begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                level_ff <= s3_ff;
            end
        end
    end

    assign level = level_ff;
    assign rise  = clk_en && (s2_ff == s3_ff) && s3_ff && !level_ff;

endmodule
`default_nettype wire

// >>> core/wdl_watchdog.sv
// Watchdog timer and power LED control with its register port.
// Assumes restart events are asynchronous pins and the host port is
// synchronous to sys_clk.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module wdl_watchdog
    import wdl_pkg::*;
#(
    parameter int HALF_CYC  = HALF_SEC_CYC,
    parameter int IRQ_LINES = 15
) (
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic                 clk_en,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    input  wire logic                 game_port_access,
    input  wire logic                 keyboard_irq,
    input  wire logic                 mouse_irq,
    input  wire logic                 kbc_port2_bit0,
    input  wire logic                 infrared_transmit,
    output logic                      infrared_receive,
    output logic      [IRQ_LINES-1:0] irq_out,
    output logic                      status_pin_a,
    output logic                      led_pin_a,
    output logic                      shared_pin_b,
    output logic                      status_pin_c,
    output logic                      led_pin_c,
    output logic                      soft_power_off
);

    logic [7:0]  timebase_ff;
    logic [7:0]  timeout_value_ff;
    logic [7:0]  config_ff;
    logic [7:0]  control_ff;
    logic [7:0]  pincfg_ff;
    logic [7:0]  count_ff;
    logic [7:0]  rdata_ff;
    logic        led_phase_ff;
    logic        status_ff;
    wdl_state_t  state_ff;
    wdl_state_t  nxt_state;
    logic        half_tick;
    logic        sec_tick;
    logic        min_tick;
    logic        unit_tick;
    logic        joy_rise;
    logic        kbd_rise;
    logic        mouse_rise;
    logic        kbc_level;
    logic        kbc_rise;
    logic        restart;
    logic        force_hit;
    logic        expire;
    logic        led_toggle;
    logic        led_assert;
    logic        led_level;
    logic        status_out;
    logic        wr_timeout;
    logic        wr_control;
    logic [3:0]  irq_sel;

    // True when a write strobe targets the given offset.
    function automatic logic wr_hit(input logic [7:0] ofs);
        return clk_en && reg_wr && (reg_addr == ofs);
    endfunction

    // Drives a level through a polarity bit.
    function automatic logic pol(input logic v, input logic inv);
        return inv ? ~v : v;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Tick source.

    wdl_prescaler #(
        .HALF_CYC (HALF_CYC)
    ) u_presc (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .half_tick (half_tick),
        .sec_tick  (sec_tick),
        .min_tick  (min_tick)
    );

    // Unit selection between seconds and minutes.
    assign unit_tick = timebase_ff[TB_MINUTES_BIT] ? min_tick
                                                   : sec_tick;

    ////////////////////////////////////////////////////////////////////
    // Restart and keyboard port force synchronisers; each event counts once on its edge.

    wdl_sync u_sync_joy (
        .sys_clk (sys_clk),
        .reset   (reset),
        .clk_en  (clk_en),
        .pin_in  (game_port_access),
        .level   (),
        .rise    (joy_rise)
    );

    wdl_sync u_sync_kbd (
        .sys_clk (sys_clk),
        .reset   (reset),
        .clk_en  (clk_en),
        .pin_in  (keyboard_irq),
        .level   (),
        .rise    (kbd_rise)
    );

    wdl_sync u_sync_mouse (
        .sys_clk (sys_clk),
        .reset   (reset),
        .clk_en  (clk_en),
        .pin_in  (mouse_irq),
        .level   (),
        .rise    (mouse_rise)
    );

    wdl_sync u_sync_kbc (
        .sys_clk (sys_clk),
        .reset   (reset),
        .clk_en  (clk_en),
        .pin_in  (kbc_port2_bit0),
        .level   (kbc_level),
        .rise    (kbc_rise)
    );

    ////////////////////////////////////////////////////////////////////
    // Event decode.
    assign restart = (joy_rise   && config_ff[CFG_JOY_BIT])
                   || (kbd_rise   && config_ff[CFG_KBD_BIT])
                   || (mouse_rise && config_ff[CFG_MOUSE_BIT]);
    assign wr_timeout = wr_hit(OFS_TIMEOUT);
    assign wr_control = wr_hit(OFS_CONTROL);
    // Force by host bit 2, or by the keyboard port while enabled.
    assign force_hit = (wr_control && reg_wdata[CTL_FORCE_BIT])
                     || (kbc_rise && control_ff[CTL_KBCEN_BIT]);
    assign expire = clk_en && (state_ff == WDL_RUN) && unit_tick
                    && (count_ff == 8'h01);

    ////////////////////////////////////////////////////////////////////
    // Counter state machine. A zero reload parks it idle.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            WDL_IDLE: begin
                if (timeout_value_ff != 8'h00) begin
                    nxt_state = WDL_RUN;
                end
            end
            WDL_RUN: begin
                if (expire) begin
                    nxt_state = WDL_DONE;
                end
            end
            WDL_DONE: begin
                nxt_state = WDL_DONE;
            end
            default: begin
                nxt_state = WDL_IDLE;
            end
        endcase
        if (force_hit) begin
            nxt_state = WDL_DONE;
        end else if (wr_timeout) begin
            nxt_state = (reg_wdata == 8'h00) ? WDL_IDLE : WDL_RUN;
        end else if (restart && timeout_value_ff != 8'h00) begin
            nxt_state = WDL_RUN;
        end else if (timeout_value_ff == 8'h00) begin
            nxt_state = WDL_IDLE;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_ff <= WDL_IDLE;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    // Count register; 8 bits bound the range to 255 units.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count_ff <= 8'h00;
        end else if (clk_en) begin
            if (force_hit) begin
                count_ff <= 8'h00;
            end else if (wr_timeout) begin
                count_ff <= reg_wdata;
            end else if (restart) begin
                count_ff <= timeout_value_ff;
            end else if (state_ff == WDL_RUN && unit_tick) begin
                count_ff <= count_ff - 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status bit. Hardware sets win over a host clear in the same cycle.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            status_ff <= 1'b0;
        end else if (clk_en) begin
            if (expire || force_hit) begin
                status_ff <= 1'b1;
            end else if (wr_control) begin
                status_ff <= reg_wdata[CTL_STATUS_BIT];
            end else if (restart) begin
                status_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Host registers. Force bit never stores, so it reads back zero.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            timebase_ff      <= RST_TIMEBASE;
            timeout_value_ff <= RST_TIMEOUT;
            config_ff        <= RST_CONFIG;
            control_ff       <= RST_CONTROL;
            pincfg_ff        <= RST_PINCFG;
        end else begin
            if (wr_hit(OFS_TIMEBASE)) begin
                timebase_ff <= reg_wdata;
            end
            if (wr_timeout) begin
                timeout_value_ff <= reg_wdata;
            end
            if (wr_hit(OFS_CONFIG)) begin
                config_ff <= reg_wdata;
            end
            if (wr_control) begin
                control_ff <= reg_wdata & 8'hEA;
            end
            if (wr_hit(OFS_PINCFG)) begin
                pincfg_ff <= reg_wdata;
            end
        end
    end

    // Read data register, valid the cycle after the read strobe.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= 8'h00;
        end else if (clk_en) begin
            rdata_ff <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    OFS_TIMEBASE: rdata_ff <= timebase_ff;
                    OFS_TIMEOUT:  rdata_ff <= timeout_value_ff;
                    OFS_CONFIG:   rdata_ff <= config_ff;
                    OFS_CONTROL:  rdata_ff <= {control_ff[7:1], status_ff};
                    OFS_PINCFG:   rdata_ff <= pincfg_ff;
                    default:      rdata_ff <= 8'h00;
                endcase
            end
        end
    end
    assign reg_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////
    // Power LED phase flips every half second for 1 Hz, half duty.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            led_phase_ff <= 1'b0;
        end else if (clk_en && half_tick) begin
            led_phase_ff <= ~led_phase_ff;
        end
    end

    assign led_toggle = control_ff[CTL_LED_BIT]
                      || (config_ff[CFG_LEDWDT_BIT] && status_ff);
    assign led_assert = led_toggle ? led_phase_ff : 1'b1;
    // Asserted means low unless polarity is set.
    assign led_level = pol(~led_assert, pincfg_ff[PIN_POL_LED_BIT]);
    assign status_out = pol(status_ff, pincfg_ff[PIN_POL_STAT_BIT]);

    ////////////////////////////////////////////////////////////////////
    // Pin muxing. The IR bit hands pins a to the infrared function.
    assign status_pin_a = (pincfg_ff[PIN_ALT_STAT_BIT]
                           && !pincfg_ff[PIN_IR_BIT])
                          ? status_out : 1'b0;
    assign led_pin_a = (pincfg_ff[PIN_ALT_LED_BIT]
                        && !pincfg_ff[PIN_IR_BIT])
                       ? led_level : 1'b0;
    assign infrared_receive = (pincfg_ff[PIN_ALT_STAT_BIT]
                               && pincfg_ff[PIN_ALT_LED_BIT]
                               && pincfg_ff[PIN_IR_BIT])
                              ? infrared_transmit : 1'b0;
    assign shared_pin_b = pincfg_ff[PIN_ALT_B_BIT]
                          ? pol(status_ff, pincfg_ff[PIN_POL_B_BIT])
                          : 1'b0;
    assign status_pin_c = status_out;
    assign led_pin_c    = led_level;
    assign soft_power_off = control_ff[7];

    ////////////////////////////////////////////////////////////////////
    // Interrupt mapping; the request line follows the status level.
    assign irq_sel = config_ff[CFG_IRQ_LSB +: 4];
    always_comb begin
        irq_out = '0;
        if (irq_sel != 4'h0 && int'(irq_sel) <= IRQ_LINES) begin
            irq_out[irq_sel - 4'h1] = status_ff;
        end
    end

endmodule
`default_nettype wire

// >>> test/wdl_watchdog_chk.sv
// Concurrent checks on the watchdog block register port and interrupt outputs.
// Assumes it is bound to wdl_watchdog and sees only its top ports.
`timescale 1ns/1ps
`default_nettype none
module wdl_watchdog_chk
    import wdl_pkg::*;
#(
    parameter int IRQ_LINES = 15
) (
    input wire logic                 sys_clk,
    input wire logic                 reset,
    input wire logic                 clk_en,
    input wire logic [7:0]           reg_addr,
    input wire logic [7:0]           reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [7:0]           reg_rdata,
    input wire logic [IRQ_LINES-1:0] irq_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////
    // Register cycles; a write followed at once by a read of one place.
    sequence s_wr_ctl(int b);
        clk_en && reg_wr && reg_addr == OFS_CONTROL && reg_wdata[b];
    endsequence
    sequence s_rd_ctl;
        clk_en && reg_rd && reg_addr == OFS_CONTROL;
    endsequence
    sequence s_wr_rd(logic [7:0] ofs);
        clk_en && reg_wr && reg_addr == ofs ##1
        clk_en && reg_rd && reg_addr == ofs;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // Read data lag the read by one cycle, so the write data sit two back.
    property p_timeout_back;
        s_wr_rd(OFS_TIMEOUT) |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_timeout_back: assert property (p_timeout_back)
        else $error("timeout value readback differs");
    property p_timebase_back;
        s_wr_rd(OFS_TIMEBASE) |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_timebase_back: assert property (p_timebase_back)
        else $error("time base readback differs");
    property p_config_back;
        s_wr_rd(OFS_CONFIG) |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_config_back: assert property (p_config_back)
        else $error("configuration readback differs");
    property p_ctrl_rsvd;
        s_rd_ctl |=> !reg_rdata[CTL_FORCE_BIT] && !reg_rdata[CTL_RSVD_BIT];
    endproperty
    a_ctrl_rsvd: assert property (p_ctrl_rsvd)
        else $error("force or reserved control bit reads one");
    property p_force;
        s_wr_ctl(CTL_FORCE_BIT) ##1 s_rd_ctl |=> reg_rdata[CTL_STATUS_BIT];
    endproperty
    a_force: assert property (p_force)
        else $error("forced time-out did not set status");
    // Only a set is checked, since an expiry may win over a host clear.
    property p_status_set;
        s_wr_ctl(CTL_STATUS_BIT) ##1 s_rd_ctl |=>
            reg_rdata == ($past(reg_wdata, 2) & 8'hEB);
    endproperty
    a_status_set: assert property (p_status_set)
        else $error("control readback after status set differs");
    property p_irq_onehot;
        $onehot0(irq_out);
    endproperty
    a_irq_onehot: assert property (p_irq_onehot)
        else $error("more than one interrupt line active");
    property p_irq_level;
        s_rd_ctl |=> reg_rdata[CTL_STATUS_BIT] || $past(irq_out) == '0;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt active while status clear");
endmodule

bind wdl_watchdog wdl_watchdog_chk #(
    .IRQ_LINES (IRQ_LINES)
) u_wdl_watchdog_chk (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .irq_out   (irq_out)
);
`default_nettype wire

// >>> test/test_wdl_watchdog.sv
// Self-checking bench for the watchdog and power LED block.
// Assumes a 50 MHz clock and a half second shortened to ten cycles.
`timescale 1ns/1ps
`default_nettype none
module test_wdl_watchdog
    import wdl_pkg::*;
;
    localparam int HC  = 10;
    localparam int SEC = 2 * HC;
    logic        sys_clk;
    logic        reset;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [2:0]  evt;
    logic        kbc;
    logic        ir_tx;
    logic        ir_rx;
    logic [14:0] irq;
    logic        stat_a;
    logic        led_a;
    logic        stat_c;
    logic        led_c;
    logic        pin_b;
    int          miscompares;
    int          check_count;

    // Clock enable is tied high; freezing is outside these scenarios.
    wdl_watchdog #(.HALF_CYC(HC)) u_wdl_watchdog (
        .sys_clk(sys_clk), .reset(reset), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .game_port_access(evt[0]), .keyboard_irq(evt[1]),
        .mouse_irq(evt[2]), .kbc_port2_bit0(kbc),
        .infrared_transmit(ir_tx), .infrared_receive(ir_rx),
        .irq_out(irq), .status_pin_a(stat_a), .led_pin_a(led_a),
        .shared_pin_b(pin_b), .status_pin_c(stat_c), .led_pin_c(led_c),
        .soft_power_off()
    );

    // Free-running system clock.
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and register port helpers.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h", $time, msg, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        q = reg_rdata;
    endtask
    // Write then read the same place with no gap between the strobes.
    task automatic wrd(input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        wr(a, d);
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        q = reg_rdata;
    endtask
    task automatic wait_stat(input int lim, output int n);
        n = 0;
        while (stat_a !== 1'b1 && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    // Pins pass a synchroniser, so each pulse is held four cycles.
    task automatic pulse(input int k);
        @(posedge sys_clk);
        if (k == 3) kbc <= 1'b1;
        else evt[k] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        kbc <= 1'b0;
        evt <= 3'b000;
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic count_hi(output int n);
        n = 0;
        repeat (4 * HC) begin
            @(negedge sys_clk);
            if (led_a === 1'b1) n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_regs();
        logic [7:0] q;
        for (int i = 1; i <= 5; i++) begin
            rd(8'hF0 + 8'(i), q);
            chk(16'(q), 16'h0000, "reset value");
        end
        wr(8'h10, 8'hFF);
        rd(8'h10, q);
        chk(16'(q), 16'h0000, "unmapped");
        wrd(OFS_CONTROL, 8'hFF, q);
        chk(16'(q), 16'h00EB, "control");
        wrd(OFS_TIMEOUT, 8'hFF, q);
        chk(16'(q), 16'h00FF, "timeout");
        wrd(OFS_TIMEBASE, 8'h80, q);
        chk(16'(q), 16'h0080, "time base");
        wrd(OFS_CONFIG, 8'hA5, q);
        chk(16'(q), 16'h00A5, "configuration");
        wr(OFS_TIMEOUT, 8'h00);
        wr(OFS_TIMEBASE, 8'h00);
        wr(OFS_CONFIG, 8'h00);
        wrd(OFS_CONTROL, 8'h00, q);
        chk(16'(q), 16'h0000, "status clear");
        $display("test regs done");
    endtask
    task automatic t_count();
        int n;
        wr(OFS_PINCFG, 8'h03);
        wr(OFS_TIMEOUT, 8'h03);
        wait_stat(4 * SEC, n);
        chk(16'(n >= 2 * SEC - 2 && n <= 3 * SEC + 3), 16'h1, "secs");
        repeat (2 * SEC) @(negedge sys_clk);
        chk(16'(stat_a), 16'h1, "halted");
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_TIMEOUT, 8'h03);
        wr(OFS_TIMEOUT, 8'h00);
        wait_stat(5 * SEC, n);
        chk(16'(stat_a), 16'h0, "disabled");
        wr(OFS_TIMEBASE, 8'h80);
        wr(OFS_TIMEOUT, 8'h02);
        wait_stat(55 * SEC, n);
        chk(16'(stat_a), 16'h0, "minute early");
        wait_stat(70 * SEC, n);
        chk(16'(stat_a), 16'h1, "minute expiry");
        wr(OFS_TIMEBASE, 8'h00);
        wr(OFS_TIMEOUT, 8'h00);
        wr(OFS_CONTROL, 8'h00);
        $display("test count done");
    endtask
    task automatic t_irq();
        wr(OFS_CONTROL, 8'h01);
        for (int ch = 0; ch < 16; ch++) begin
            wr(OFS_CONFIG, 8'(ch << 4));
            @(negedge sys_clk);
            chk(16'(irq), 16'((1 << ch) >> 1), "map");
        end
        wr(OFS_CONTROL, 8'h00);
        @(negedge sys_clk);
        chk(16'(irq), 16'h0000, "irq level");
        // All three status pins inverted, with pin b selected as well.
        wr(OFS_PINCFG, 8'h57);
        @(negedge sys_clk);
        chk(16'(stat_a), 16'h1, "inverted pin");
        chk(16'(stat_c), 16'h1, "inverted pin c");
        chk(16'(pin_b), 16'h1, "inverted pin b");
        wr(OFS_PINCFG, 8'h03);
        wr(OFS_CONFIG, 8'h00);
        $display("test irq done");
    endtask
    task automatic t_restart();
        logic [7:0] q;
        int         n;
        for (int k = 0; k < 3; k++) begin
            wr(OFS_TIMEOUT, 8'h03);
            wr(OFS_CONFIG, 8'(1 << k));
            wrd(OFS_CONTROL, 8'h04, q);
            chk(16'(q), 16'h0001, "force");
            pulse(k);
            chk(16'(stat_a), 16'h0, "restart clears");
            wait_stat(4 * SEC, n);
            chk(16'(n >= 24 && stat_a === 1'b1), 16'h1, "reload");
        end
        wr(OFS_CONFIG, 8'h00);
        for (int k = 0; k < 3; k++) begin
            pulse(k);
            chk(16'(stat_a), 16'h1, "disabled source");
        end
        wr(OFS_TIMEOUT, 8'h00);
        wr(OFS_CONTROL, 8'h08);
        pulse(3);
        chk(16'(stat_a), 16'h1, "port force");
        wr(OFS_CONTROL, 8'h00);
        pulse(3);
        chk(16'(stat_a), 16'h0, "port ignored");
        $display("test restart done");
    endtask
    task automatic t_led();
        int n;
        wr(OFS_PINCFG, 8'h23);
        count_hi(n);
        chk(16'(n), 16'(4 * HC), "steady high");
        wr(OFS_CONTROL, 8'h02);
        count_hi(n);
        chk(16'(n), 16'(2 * HC), "toggle");
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_CONFIG, 8'h08);
        count_hi(n);
        chk(16'(n), 16'(4 * HC), "no status");
        wr(OFS_CONTROL, 8'h01);
        count_hi(n);
        chk(16'(n), 16'(2 * HC), "status toggle");
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_PINCFG, 8'h03);
        count_hi(n);
        chk(16'(n), 16'h0, "steady low");
        chk(16'(led_c), 16'h0, "led pin c low");
        wr(OFS_PINCFG, 8'h83);
        ir_tx <= 1'b1;
        @(negedge sys_clk);
        chk(16'(ir_rx), 16'h1, "infrared high");
        @(posedge sys_clk);
        ir_tx <= 1'b0;
        @(negedge sys_clk);
        chk(16'(ir_rx), 16'h0, "infrared low");
        $display("test led done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence; the run takes about three thousand cycles.
    initial begin
        reset       = 1'b1;
        reg_addr    = 8'h00;
        reg_wdata   = 8'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        evt         = 3'b000;
        kbc         = 1'b0;
        ir_tx       = 1'b0;
        miscompares = 0;
        check_count = 0;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        t_regs();
        t_count();
        t_irq();
        t_restart();
        t_led();
        end_of_test();
    end

    // Watchdog at nearly seven times the expected run length.
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        end_of_test();
    end
endmodule
`default_nettype wire
